// file: pwc_consts.svh
`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define PWC_OFS_ON_INTERVAL   8'h00
`define PWC_OFS_OFF_INTERVAL  8'h04
`define PWC_OFS_CONFIG        8'h08

// ==========================================================================
// reset values
`define PWC_RST_ON_INTERVAL   16'h0000
`define PWC_RST_OFF_INTERVAL  16'hffff
`define PWC_RST_PREDIV        4'h0

// ==========================================================================
// configuration field positions
`define PWC_CFG_RUN_BIT       0
`define PWC_CFG_CLK_SEL_BIT   1
`define PWC_CFG_INVERT_BIT    2
`define PWC_CFG_PREDIV_LSB    3
`define PWC_CFG_PREDIV_MSB    6

// ==========================================================================
// clock source choice encodings
`define PWC_CLK_SEL_FAST      1'b0
`define PWC_CLK_SEL_SLOW      1'b1

`endif

// file: pwc_pkg.sv
package pwc_pkg;

  // ========================================================================
  // register bus request, one cycle per access
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pwc_bus_req_s;

  // ========================================================================
  // configuration fields as seen by the waveform logic
  typedef struct packed {
    logic [3:0] prediv;
    logic       invert;
    logic       clk_sel;
    logic       run;
  } pwc_cfg_s;

  // ========================================================================
  // waveform sequencer states
  typedef enum logic [1:0] {
    PWC_ST_IDLE,
    PWC_ST_ON,
    PWC_ST_OFF,
    PWC_ST_FULL
  } pwc_state_e;

endpackage : pwc_pkg

// file: pwc_tick_gen.sv
`timescale 1ns/1ps
`include "pwc_consts.svh"

// counting clock: samples both source clock pins, picks one, divides by
// prediv+1 and emits one tick per counting period
module pwc_tick_gen
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // source clock pins
  input  wire logic       fast_src_in,
  input  wire logic       slow_src_in,
  // control
  input  wire logic       enable_in,
  input  wire logic       clk_sel_in,
  input  wire logic [3:0] prediv_in,
  // counting tick
  output logic            tick_out
);

  // ========================================================================
  // synchronisers and edge detect
  logic [2:0] fast_sync;
  logic [2:0] slow_sync;
  logic [3:0] div_cnt;
  logic       src_edge;

  // stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fast_sync <= 3'h0;
      slow_sync <= 3'h0;
    end
    else
    begin
      fast_sync <= {fast_sync[1:0], fast_src_in};
      slow_sync <= {slow_sync[1:0], slow_src_in};
    end
  end

  assign src_edge = (clk_sel_in == `PWC_CLK_SEL_SLOW) ? (slow_sync[1] & ~slow_sync[2])
                                                     : (fast_sync[1] & ~fast_sync[2]);

  // ========================================================================
  // pre-divider; held cleared while stopped, which also silences the ticks
  // divide by prediv+1
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt  <= 4'h0;
      tick_out <= 1'b0;
    end
    else if (!enable_in)
    begin
      div_cnt  <= 4'h0;
      tick_out <= 1'b0;
    end
    else if (src_edge)
    begin
      if (div_cnt >= prediv_in)
      begin
        div_cnt  <= 4'h0;
        tick_out <= 1'b1;
      end
      else
      begin
        div_cnt  <= div_cnt + 4'h1;
        tick_out <= 1'b0;
      end
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end

endmodule : pwc_tick_gen

// file: pwc_hold_regs.sv
`timescale 1ns/1ps
`include "pwc_consts.svh"

// holding registers for the two interval values; pending once both
// registers (all four bytes) carry fresh values
module pwc_hold_regs
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // write side
  input  wire logic        on_wr_in,
  input  wire logic        off_wr_in,
  input  wire logic [15:0] wdata_in,
  // transfer side
  input  wire logic        xfer_in,
  output logic             pending_out,
  output logic [15:0]      on_hold_out,
  output logic [15:0]      off_hold_out
);

  logic on_full;
  logic off_full;

  // ========================================================================
  // held values
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      on_hold_out  <= `PWC_RST_ON_INTERVAL;
      off_hold_out <= `PWC_RST_OFF_INTERVAL;
    end
    else
    begin
      if (on_wr_in)
        on_hold_out <= wdata_in;
      if (off_wr_in)
        off_hold_out <= wdata_in;
    end
  end

  // ========================================================================
  // marked empty after transfer
  // a write in the transfer cycle keeps its flag: set wins over clear
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      on_full  <= 1'b0;
      off_full <= 1'b0;
    end
    else
    begin
      on_full  <= on_wr_in | (on_full & ~xfer_in);
      off_full <= off_wr_in | (off_full & ~xfer_in);
    end
  end

  assign pending_out = on_full & off_full;

endmodule : pwc_hold_regs

// file: pwc_top.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "pwc_consts.svh"

// Function
// - An off-interval value of n keeps the waveform off for n+1 counting periods.
// - An off-interval value of zero holds the output continuously on (full on).
// - The selected source clock is divided by the pre-divider field plus one.
// - The 16-bit interval counter decrements once per divided counting period.
// - A pre-divider of zero counts directly at the selected source rate.
// - The invert bit at 1 drives the on state low, at 0 drives it high.
// - The source choice bit picks the slow clock at 1 and the fast clock at 0.
// - With run at 0 the counters are cleared and the sequencer forced off.
// - With run at 0 the output sits at the inactive level given by the invert bit.
// - Clearing run leaves both interval registers intact and accessible.
// - With run at 0 the counting ticks stop so the waveform logic stays idle.
// - An on value of n gives n+1 on periods; zero on with nonzero off is full off.
// - Interval writes go to holding registers, loaded at end of off count, in full on, or while idle.
// - After a transfer the holding registers are empty, unless written in that cycle, and reads show active values.
// - A sleep request clears the counters and forces state and output off.
module pwc_top
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  // register port
  input  wire pwc_pkg::pwc_bus_req_s bus_req_in,
  output logic [31:0]                rd_data_out,
  // counting source clocks, sampled as plain pins
  input  wire logic                  fast_src_in,
  input  wire logic                  slow_src_in,
  // sleep request from the power_clock_reset_unit
  input  wire logic                  sleep_req_in,
  // waveform pin
  output logic                       pwm_out_out
);

  import pwc_pkg::*;

  // ========================================================================
  // declarations
  logic [15:0] on_interval_value;
  logic [15:0] off_interval_value;
  pwc_cfg_s    cfg;
  pwc_state_e  state;
  pwc_state_e  next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        tick;
  logic        active;
  logic        pending;
  logic        xfer;
  logic [15:0] on_hold;
  logic [15:0] off_hold;
  logic        on_wr;
  logic        off_wr;
  logic        cfg_wr;
  logic        wave_on;

  // the sequencer only moves while running and awake
  assign active = cfg.run & ~sleep_req_in;

  // ========================================================================
  // register decode
  assign on_wr  = bus_req_in.wr & (bus_req_in.addr == `PWC_OFS_ON_INTERVAL);
  assign off_wr = bus_req_in.wr & (bus_req_in.addr == `PWC_OFS_OFF_INTERVAL);
  assign cfg_wr = bus_req_in.wr & (bus_req_in.addr == `PWC_OFS_CONFIG);

  // ========================================================================
  // configuration register
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg <= '{prediv: `PWC_RST_PREDIV, invert: 1'b0, clk_sel: 1'b0, run: 1'b0};
    end
    else if (cfg_wr)
    begin
      cfg.prediv  <= bus_req_in.wdata[`PWC_CFG_PREDIV_MSB:`PWC_CFG_PREDIV_LSB];
      cfg.invert  <= bus_req_in.wdata[`PWC_CFG_INVERT_BIT];
      cfg.clk_sel <= bus_req_in.wdata[`PWC_CFG_CLK_SEL_BIT];
      cfg.run     <= bus_req_in.wdata[`PWC_CFG_RUN_BIT];
    end
  end

  // ========================================================================
  // holding registers
  // writes land in holding registers
  pwc_hold_regs u_hold (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .on_wr_in     (on_wr),
    .off_wr_in    (off_wr),
    .wdata_in     (bus_req_in.wdata[15:0]),
    .xfer_in      (xfer),
    .pending_out  (pending),
    .on_hold_out  (on_hold),
    .off_hold_out (off_hold)
  );

  // ========================================================================
  // counting tick
  // ticks stop while stopped
  pwc_tick_gen u_tick (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .fast_src_in (fast_src_in),
    .slow_src_in (slow_src_in),
    .enable_in   (active),
    .clk_sel_in  (cfg.clk_sel),
    .prediv_in   (cfg.prediv),
    .tick_out    (tick)
  );

  // ========================================================================
  // holding transfer point
  // end of off count, full on, or while idle
  // stopped counts as a completed off count so software sees its writes
  always_comb
  begin
    xfer = 1'b0;
    if (pending)
    begin
      if (state == PWC_ST_IDLE || state == PWC_ST_FULL)
        xfer = 1'b1;
      else if (state == PWC_ST_OFF && tick && cnt == 16'h0000)
        xfer = 1'b1;
    end
  end

  // ========================================================================
  // active interval registers, untouched by run
  // kept across stop
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      on_interval_value  <= `PWC_RST_ON_INTERVAL;
      off_interval_value <= `PWC_RST_OFF_INTERVAL;
    end
    else if (xfer)
    begin
      on_interval_value  <= on_hold;
      off_interval_value <= off_hold;
    end
  end

  // ========================================================================
  // sequencer next state and count
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      PWC_ST_IDLE:
      begin
        next_cnt = 16'h0000;
        if (active)
        begin
          // zero off interval is full on
          if (off_interval_value == 16'h0000)
            next_state = PWC_ST_FULL;
          // zero on interval is full off
          else if (on_interval_value == 16'h0000)
          begin
            next_state = PWC_ST_OFF;
            next_cnt   = off_interval_value;
          end
          else
          begin
            next_state = PWC_ST_ON;
            next_cnt   = on_interval_value;
          end
        end
      end
      PWC_ST_ON:
      begin
        if (tick)
        begin
          if (cnt == 16'h0000)
          begin
            next_state = PWC_ST_OFF;
            next_cnt   = off_interval_value;
          end
          else
          begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      PWC_ST_OFF:
      begin
        if (tick)
        begin
          if (cnt == 16'h0000)
          begin
            // pick the next state from the held values if they transfer here, else from the active values
            if (xfer && off_hold == 16'h0000)
              next_state = PWC_ST_FULL;
            else if (xfer && on_hold == 16'h0000)
            begin
              next_state = PWC_ST_OFF;
              next_cnt   = off_hold;
            end
            else if (xfer)
            begin
              next_state = PWC_ST_ON;
              next_cnt   = on_hold;
            end
            else if (on_interval_value == 16'h0000)
            begin
              next_state = PWC_ST_OFF;
              next_cnt   = off_interval_value;
            end
            else
            begin
              next_state = PWC_ST_ON;
              next_cnt   = on_interval_value;
            end
          end
          else
          begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      PWC_ST_FULL:
      begin
        next_cnt = 16'h0000;
        // leave full on once a nonzero off value has been taken
        if (xfer && off_hold != 16'h0000)
          next_state = PWC_ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // sequencer registers
  // stop clears counter and forces off
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= PWC_ST_IDLE;
      cnt   <= 16'h0000;
    end
    else if (!active)
    begin
      state <= PWC_ST_IDLE;
      cnt   <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ========================================================================
  // waveform pin
  assign wave_on = (state == PWC_ST_ON) || (state == PWC_ST_FULL);

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pwm_out_out <= 1'b0;
    else if (!active)
      pwm_out_out <= cfg.invert;
    else
      pwm_out_out <= wave_on ^ cfg.invert;
  end

  // ========================================================================
  // read data, valid the cycle after the strobe only
  // reads show active values
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rd_data_out <= 32'h0000_0000;
    else if (bus_req_in.rd)
    begin
      unique case (bus_req_in.addr)
        `PWC_OFS_ON_INTERVAL:  rd_data_out <= {16'h0000, on_interval_value};
        `PWC_OFS_OFF_INTERVAL: rd_data_out <= {16'h0000, off_interval_value};
        `PWC_OFS_CONFIG:       rd_data_out <= {25'h0, cfg.prediv, cfg.invert,
                                               cfg.clk_sel, cfg.run};
        default:               rd_data_out <= 32'h0000_0000;
      endcase
    end
    else
      rd_data_out <= 32'h0000_0000;
  end

endmodule : pwc_top

// file: pwc_top_props.sv
`timescale 1ns/1ps
`include "pwc_consts.svh"

// ==========================================================================
// checker on the top ports
module pwc_top_props
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  // register port
  input  wire pwc_pkg::pwc_bus_req_s bus_req_in,
  input  wire logic [31:0]           rd_data_out,
  // pins
  input  wire logic                  fast_src_in,
  input  wire logic                  slow_src_in,
  input  wire logic                  sleep_req_in,
  input  wire logic                  pwm_out_out
);
  logic [6:0]  cfg_q;
  logic [15:0] on_q;
  logic [15:0] off_q;
  logic        inv_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // shadow of written values; each interval shadow updates on its own write, not at transfer
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q <= 7'h00;
      on_q  <= 16'h0000;
      off_q <= 16'hffff;
    end
    else if (bus_req_in.wr)
    begin
      if (bus_req_in.addr == `PWC_OFS_CONFIG) cfg_q <= bus_req_in.wdata[6:0];
      if (bus_req_in.addr == `PWC_OFS_ON_INTERVAL) on_q <= bus_req_in.wdata[15:0];
      if (bus_req_in.addr == `PWC_OFS_OFF_INTERVAL) off_q <= bus_req_in.wdata[15:0];
    end
  end
  assign inv_q = cfg_q[2];

  // ========================================================================
  // running with a steady config for three cycles
  sequence s_steady(c);
    (cfg_q[0] && !sleep_req_in && $stable(cfg_q) && c) [*3];
  endsequence

  property p_rd_quiet;    !bus_req_in.rd |=> rd_data_out == 32'h0; endproperty
  property p_rd_unmapped; bus_req_in.rd && bus_req_in.addr > 8'h08 |=> rd_data_out == 32'h0;
  endproperty
  property p_rd_cfg;
    bus_req_in.rd && bus_req_in.addr == `PWC_OFS_CONFIG |=> rd_data_out == {25'h0, $past(cfg_q)};
  endproperty
  property p_stop_level;  !cfg_q[0] |=> pwm_out_out == $past(inv_q); endproperty
  property p_sleep_level; sleep_req_in |=> pwm_out_out == $past(inv_q); endproperty
  property p_stop_quiet;  (!cfg_q[0] && $stable(cfg_q)) [*2] |=> $stable(pwm_out_out);
  endproperty
  property p_full_on;     s_steady(off_q == 16'h0) |-> pwm_out_out == !inv_q; endproperty
  property p_full_off;
    s_steady(on_q == 16'h0 && off_q != 16'h0) |-> pwm_out_out == inv_q;
  endproperty

  a_rd_quiet:    assert property (p_rd_quiet)    else $error("read data outside window");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_rd_cfg:      assert property (p_rd_cfg)      else $error("config readback wrong");
  a_stop_level:  assert property (p_stop_level)  else $error("stopped level wrong");
  a_sleep_level: assert property (p_sleep_level) else $error("sleep level wrong");
  a_stop_quiet:  assert property (p_stop_quiet)  else $error("output moved while stopped");
  a_full_on:     assert property (p_full_on)     else $error("full on level wrong");
  a_full_off:    assert property (p_full_off)    else $error("full off level wrong");
endmodule : pwc_top_props

// file: pwc_load_model.sv
`timescale 1ns/1ps

// ==========================================================================
// load on the waveform pin: measures the length of each level in cycles
module pwc_load_model
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // waveform pin
  input  wire logic        pwm_in,
  // measured lengths
  output logic [15:0]      hi_len_out,
  output logic [15:0]      lo_len_out,
  output logic [15:0]      run_len_out
);
  logic last;

  // a level change closes the run; saturates so long idles do not wrap
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last        <= 1'b0;
      hi_len_out  <= 16'h0;
      lo_len_out  <= 16'h0;
      run_len_out <= 16'h0;
    end
    else
    begin
      last <= pwm_in;
      if (pwm_in != last)
      begin
        if (last) hi_len_out <= run_len_out + 16'h1;
        else lo_len_out <= run_len_out + 16'h1;
        run_len_out <= 16'h0;
      end
      else if (run_len_out != 16'hffff) run_len_out <= run_len_out + 16'h1;
    end
  end
endmodule : pwc_load_model

// file: pwc_top_tb.sv
`timescale 1ns/1ps

module pwc_top_tb;
  import pwc_pkg::*;
  logic         core_clk_in = 1'b0;
  logic         rst_n_in    = 1'b0;
  logic         fast_src    = 1'b0;
  logic         slow_src    = 1'b0;
  logic         sleep_req   = 1'b0;
  pwc_bus_req_s bus_req     = '0;
  logic [31:0]  rd_data;
  logic         pwm;
  logic [15:0]  hi_len;
  logic [15:0]  lo_len;
  logic [15:0]  run_len;
  int           n_errors    = 0;
  int           compares    = 0;

  // ========================================================================
  // clocks: sources are 4 and 16 core cycles long, offset from the core edge
  always #4 core_clk_in = ~core_clk_in;
  initial begin #3; forever #16 fast_src = ~fast_src; end
  initial begin #3; forever #64 slow_src = ~slow_src; end

  pwc_top uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req),
    .rd_data_out(rd_data), .fast_src_in(fast_src), .slow_src_in(slow_src),
    .sleep_req_in(sleep_req), .pwm_out_out(pwm));
  pwc_load_model u_load (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .pwm_in(pwm),
    .hi_len_out(hi_len), .lo_len_out(lo_len), .run_len_out(run_len));

  // ========================================================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc

  // one-cycle strobes; the leading edge wait leaves a gap between accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_in);
    bus_req <= '0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_in);
    bus_req <= '0;
    #1;
    check(name, rd_data, exp);
  endtask : rd_chk

  // stop first so the interval pair transfers while idle
  task automatic prog(input logic [31:0] on, input logic [31:0] off, input logic [31:0] c);
    wr(8'h08, c & 32'h7e);
    wr(8'h00, on);
    wr(8'h04, off);
    wr(8'h08, c);
  endtask : prog

  // ========================================================================
  // scenarios
  task automatic t_reset;
    check("pwm", {31'h0, pwm}, 32'h0);
    rd_chk("on", 8'h00, 32'h0);
    rd_chk("off", 8'h04, 32'hffff);
    rd_chk("cfg", 8'h08, 32'h0);
    rd_chk("unmapped", 8'h0c, 32'h0);
  endtask : t_reset

  task automatic t_wave(input int on, input int off, input logic [31:0] c);
    int k;
    int ha;
    int hb;
    k  = (int'(c[6:3]) + 1) * (c[1] ? 16 : 4);
    ha = (on + 1) * k;
    hb = (off + 1) * k;
    prog(32'(on), 32'(off), c);
    cyc(3 * (on + off + 2) * k);
    check("hi_len", {16'h0, hi_len}, 32'(c[2] ? hb : ha));
    check("lo_len", {16'h0, lo_len}, 32'(c[2] ? ha : hb));
  endtask : t_wave

  task automatic t_full(input logic [31:0] on, input logic [31:0] off, input logic [31:0] c,
                        input logic lvl);
    prog(on, off, c);
    cyc(100);
    check("full_lvl", {31'h0, pwm}, {31'h0, lvl});
    check("full_run", {31'h0, run_len >= 16'd90}, 32'h1);
  endtask : t_full

  // in full on a complete interval pair is taken at once, not at an off count end
  task automatic t_full_load;
    prog(32'h5, 32'h0, 32'h01);
    cyc(20);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h3);
    rd_chk("full_on_new", 8'h00, 32'h2);
    rd_chk("full_off_new", 8'h04, 32'h3);
    cyc(84);
    check("full_hi", {16'h0, hi_len}, 32'd12);
    check("full_lo", {16'h0, lo_len}, 32'd16);
  endtask : t_full_load

  task automatic t_hold;
    prog(32'h1, 32'h2, 32'h01);
    cyc(40);
    wr(8'h00, 32'h3);
    rd_chk("on_hold", 8'h00, 32'h1);
    cyc(40);
    rd_chk("on_half", 8'h00, 32'h1);
    wr(8'h04, 32'h4);
    cyc(40);
    rd_chk("on_new", 8'h00, 32'h3);
    rd_chk("off_new", 8'h04, 32'h4);
    cyc(150);
    check("hi_new", {16'h0, hi_len}, 32'd16);
    check("lo_new", {16'h0, lo_len}, 32'd20);
  endtask : t_hold

  task automatic t_stop;
    prog(32'h1, 32'h2, 32'h01);
    cyc(40);
    wr(8'h08, 32'h04);
    cyc(2);
    check("stop_lvl", {31'h0, pwm}, 32'h1);
    rd_chk("on_kept", 8'h00, 32'h1);
    rd_chk("off_kept", 8'h04, 32'h2);
    wr(8'h00, 32'h7);
    wr(8'h04, 32'h9);
    rd_chk("on_idle", 8'h00, 32'h7);
    rd_chk("off_idle", 8'h04, 32'h9);
    cyc(60);
    check("stop_run", {31'h0, run_len >= 16'd60}, 32'h1);
  endtask : t_stop

  task automatic t_sleep;
    prog(32'h1, 32'h2, 32'h01);
    cyc(40);
    @(posedge core_clk_in);
    sleep_req <= 1'b1;
    cyc(3);
    check("sleep_lvl", {31'h0, pwm}, 32'h0);
    cyc(20);
    check("sleep_run", {31'h0, run_len >= 16'd20}, 32'h1);
    @(posedge core_clk_in);
    sleep_req <= 1'b0;
  endtask : t_sleep

  // ========================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    // fast plain, prediv 2, slow source, inverted polarity
    t_wave(1, 2, 32'h01);
    t_wave(1, 2, 32'h11);
    t_wave(3, 1, 32'h03);
    t_wave(2, 5, 32'h05);
    t_full(32'h5, 32'h0, 32'h01, 1'b1);
    t_full(32'h0, 32'h4, 32'h01, 1'b0);
    t_full(32'h5, 32'h0, 32'h05, 1'b0);
    t_full_load;
    t_hold;
    t_stop;
    t_sleep;
    end_of_test;
  end

  initial
  begin
    repeat (40000) @(posedge core_clk_in);
    n_errors++;
    end_of_test;
  end
endmodule : pwc_top_tb

bind pwc_top pwc_top_props u_props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .bus_req_in(bus_req_in), .rd_data_out(rd_data_out), .fast_src_in(fast_src_in),
  .slow_src_in(slow_src_in), .sleep_req_in(sleep_req_in), .pwm_out_out(pwm_out_out));
